// *** design/ebct_regs.vh ***
// Purpose: constants for the external bus channel timing configuration block
// Assumes: AXI4-Lite with 32-bit data, byte addresses; one channel per pair of words
// Notes: the 64-bit channel control register is split into a low and a high word
// Functional notes
// RULE1 - page mode: page wait field gives 0..3 waits on later burst beats
// RULE2 - normal or ready mode: page wait above normal wait forms six-bit count 0..62
// RULE3 - normal wait count governs the first cycle of every access
// RULE4 - all-ones count, no page mode, no ready mode selects external acknowledge
// RULE5 - ready mode: lowest wait bit picks dynamic or static, count stays even; code clears that bit and waits for ready on every beat
// RULE6 - software keeps normal wait above page wait in page mode
// RULE7 - four-bit channel size field, code zero means 1 MB
// RULE8 - byte control 0: strobes on reads and writes; 1: writes only
// RULE9 - ready bit 1 turns acknowledge pin into active-high ready input
// RULE10 - software never combines ready mode with page mode
// RULE11 - bus speed 00 quarter, 01 third, 10 half, 11 full clock
// RULE12 - channel enable 0 means no external accesses at all
// RULE13 - three-bit setup/hold field adds waits, zero adds none
// RULE14 - setup/hold waits sit in four phases around chip select and strobe
// RULE15 - channel 0 reset defaults from pins, other channels reset to zero
// RULE16 - bursts step the address upward by one per beat from zero
// RULE17 - ready driven active high, sampled only after wait count elapses
// RULE18 - acknowledge synchronised, never accepted on two consecutive cycles
// RULE19 - software matches bus speed to the system clock ratio
// RULE20 - waits and setup/hold counted in channel operating clock ticks
`ifndef EBCT_REGS_VH
`define EBCT_REGS_VH
`define EBCT_CTRL_LO_OFS   12'h000
`define EBCT_CTRL_HI_OFS   12'h004
`define EBCT_STATUS_OFS    12'h100
`define EBCT_CH_STRIDE_LG  3
`define EBCT_F_PWT_HI      17
`define EBCT_F_PWT_LO      16
`define EBCT_F_WT_HI       15
`define EBCT_F_WT_LO       12
`define EBCT_F_CS_HI       11
`define EBCT_F_CS_LO       8
`define EBCT_F_BC          7
`define EBCT_F_RDY         6
`define EBCT_F_SP_HI       5
`define EBCT_F_SP_LO       4
`define EBCT_F_ME          3
`define EBCT_F_SETUP_HOLD_WAIT_HI     2
`define EBCT_F_SETUP_HOLD_WAIT_LO     0
`define EBCT_F_PM_HI       19
`define EBCT_F_PM_LO       18
`define EBCT_LO_MASK       32'h000F_FFFF
`define EBCT_HI_MASK       32'hFFFF_0000
`define EBCT_WAIT_ACK      6'h3F
`define EBCT_CH0_PWT       2'h3
`define EBCT_CH0_WT_HI     3'h7
`define EBCT_CH0_CS        4'h2
`define EBCT_SP_QUARTER    2'h0
`define EBCT_SP_THIRD      2'h1
`define EBCT_SP_HALF       2'h2
`define EBCT_DIV_QUARTER   2'h3
`define EBCT_DIV_THIRD     2'h2
`define EBCT_DIV_HALF      2'h1
`define EBCT_RESP_OKAY     2'h0
`define EBCT_RESP_SLVERR   2'h2
`endif

// *** design/ebct_channel_timing.v ***
// Purpose: per-channel timing configuration and access sequencer of an external bus
// Assumes: inputs synchronous to CLK except ACK_READY_IN, which is synchronised; one access request handshake shared by all channels
// Notes: registers over AXI4-Lite; straps taken on the first edge after RST falls
`timescale 1ns/1ps
`include "ebct_regs.vh"
module ebct_channel_timing #(
  parameter NCH = 8
) (
  input  wire              CLK,
  input  wire              RST,
  input  wire [11:0]       AWADDR,
  input  wire              AWVALID,
  output wire              AWREADY,
  input  wire [31:0]       WDATA,
  input  wire [3:0]        WSTRB,
  input  wire              WVALID,
  output wire              WREADY,
  output reg  [1:0]        BRESP,
  output reg               BVALID,
  input  wire              BREADY,
  input  wire [11:0]       ARADDR,
  input  wire              ARVALID,
  output wire              ARREADY,
  output reg  [31:0]       RDATA,
  output reg  [1:0]        RRESP,
  output reg               RVALID,
  input  wire              RREADY,
  input  wire [1:0]        STRAP_DATA_54,
  input  wire [2:0]        STRAP_ADDR_876,
  input  wire [2:0]        REQ_CH,
  input  wire              REQ_VALID,
  input  wire              REQ_WRITE,
  input  wire [1:0]        REQ_BEATS,
  output wire              REQ_READY,
  input  wire [3:0]        REQ_BYTES,
  input  wire              ACK_READY_IN,
  output reg               CE_N,
  output reg               STROBE_N,
  output reg  [3:0]        BYTE_STROBE_N,
  output reg  [1:0]        BEAT_ADDR,
  output reg               DONE,
  output reg               ERR
);
  // sequencer states
  localparam S_IDLE = 3'd0;
  localparam S_AS   = 3'd1;
  localparam S_CS   = 3'd2;
  localparam S_WAIT = 3'd3;
  localparam S_ACK  = 3'd4;
  localparam S_CH   = 3'd5;
  localparam S_AH   = 3'd6;

  reg  [31:0]     lo_q [0:NCH-1];
  reg  [31:0]     hi_q [0:NCH-1];
  reg             aw_q, w_q;
  reg  [11:0]     awa_q;
  reg  [31:0]     wd_q;
  reg  [3:0]      ws_q;
  reg             rst_seen_q;
  reg  [2:0]      st_q;
  reg  [2:0]      ch_q;
  reg             wr_q;
  reg  [1:0]      beats_q;
  reg  [3:0]      bytes_q;
  reg  [5:0]      cnt_q;
  reg  [1:0]      div_q;
  reg             sync1_q, sync2_q, sync3_q;
  reg             first_q;
  integer         i;

  wire [31:0] cfg      = lo_q[ch_q];
  wire [1:0]  page_wait_time      = cfg[`EBCT_F_PWT_HI:`EBCT_F_PWT_LO];
  wire [3:0]  wt       = cfg[`EBCT_F_WT_HI:`EBCT_F_WT_LO];
  wire [5:0]  wait6    = {page_wait_time, wt};                                        // RULE2
  wire        page     = cfg[`EBCT_F_PM_HI:`EBCT_F_PM_LO] != 2'h0;
  wire        rdy_mode = cfg[`EBCT_F_RDY];                                 // RULE9
  wire        ack_mode = (wait6 == `EBCT_WAIT_ACK) && !page && !rdy_mode;  // RULE4
  wire [5:0]  wait_rdy = {wait6[5:1], 1'b0};                               // RULE5
  wire [2:0]  setup_hold_wait     = cfg[`EBCT_F_SETUP_HOLD_WAIT_HI:`EBCT_F_SETUP_HOLD_WAIT_LO];
  wire [1:0]  sp       = cfg[`EBCT_F_SP_HI:`EBCT_F_SP_LO];
  wire [1:0]  div_max  = (sp == `EBCT_SP_QUARTER) ? `EBCT_DIV_QUARTER :     // RULE11
                         (sp == `EBCT_SP_THIRD)   ? `EBCT_DIV_THIRD :
                         (sp == `EBCT_SP_HALF)    ? `EBCT_DIV_HALF : 2'h0;
  wire        tick     = (div_q == 2'h0);                                  // RULE20
  wire        ack_ev   = sync2_q && !sync3_q;                              // RULE18
  wire        ch_on    = lo_q[REQ_CH][`EBCT_F_ME];
  wire [2:0]  rch      = ARADDR[`EBCT_CH_STRIDE_LG+2:`EBCT_CH_STRIDE_LG];
  wire [2:0]  wch      = awa_q[`EBCT_CH_STRIDE_LG+2:`EBCT_CH_STRIDE_LG];
  wire        w_go     = aw_q && w_q && !BVALID;
  wire        r_lo     = ARADDR[`EBCT_CH_STRIDE_LG-1:0] == `EBCT_CTRL_LO_OFS;
  wire        r_hi     = ARADDR[`EBCT_CH_STRIDE_LG-1:0] == `EBCT_CTRL_HI_OFS;
  wire        r_chok   = ARADDR[11:`EBCT_CH_STRIDE_LG] < NCH;
  wire [31:0] wmask    = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};

  assign AWREADY   = !aw_q;
  assign WREADY    = !w_q;
  assign ARREADY   = !RVALID;
  assign REQ_READY = (st_q == S_IDLE) && !rst_seen_q;

  // write channel capture, either order
  always @(posedge CLK)
  begin
    if (RST)
    begin
      aw_q  <= 1'b0;
      w_q   <= 1'b0;
      awa_q <= 12'h000;
      wd_q  <= 32'h0000_0000;
      ws_q  <= 4'h0;
    end
    else
    begin
      if (AWVALID && !aw_q)
      begin
        aw_q  <= 1'b1;
        awa_q <= AWADDR;
      end
      if (WVALID && !w_q)
      begin
        w_q  <= 1'b1;
        wd_q <= WDATA;
        ws_q <= WSTRB;
      end
      if (w_go)
      begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
      end
    end
  end

  // write response and register update, straps taken on the first edge after reset
  always @(posedge CLK)
  begin
    if (RST)
    begin
      BVALID     <= 1'b0;
      BRESP      <= `EBCT_RESP_OKAY;
      rst_seen_q <= 1'b1;
      for (i = 0; i < NCH; i = i + 1)
      begin
        lo_q[i] <= 32'h0000_0000;   // RULE15
        hi_q[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      rst_seen_q <= 1'b0;
      if (rst_seen_q)
      begin
        lo_q[0][`EBCT_F_PWT_HI:`EBCT_F_PWT_LO] <= `EBCT_CH0_PWT;             // RULE15
        lo_q[0][`EBCT_F_WT_HI:`EBCT_F_WT_LO]   <= {`EBCT_CH0_WT_HI, ~STRAP_DATA_54[0]};
        lo_q[0][`EBCT_F_CS_HI:`EBCT_F_CS_LO]   <= `EBCT_CH0_CS;
        lo_q[0][`EBCT_F_BC]                    <= STRAP_DATA_54[1];
        lo_q[0][`EBCT_F_SP_HI:`EBCT_F_SP_LO]   <= STRAP_ADDR_876[1:0];
        lo_q[0][`EBCT_F_ME]                    <= STRAP_ADDR_876[2];
      end
      if (BVALID && BREADY)
        BVALID <= 1'b0;
      if (w_go)
      begin
        BVALID <= 1'b1;
        BRESP  <= `EBCT_RESP_SLVERR;
        if (awa_q[11:`EBCT_CH_STRIDE_LG] < NCH)
        begin
          if (awa_q[`EBCT_CH_STRIDE_LG-1:0] == `EBCT_CTRL_LO_OFS)
          begin
            lo_q[wch] <= ((lo_q[wch] & ~wmask) | (wd_q & wmask)) & `EBCT_LO_MASK; // RULE7
            BRESP     <= `EBCT_RESP_OKAY;
          end
          if (awa_q[`EBCT_CH_STRIDE_LG-1:0] == `EBCT_CTRL_HI_OFS)
          begin
            hi_q[wch] <= ((hi_q[wch] & ~wmask) | (wd_q & wmask)) & `EBCT_HI_MASK;
            BRESP     <= `EBCT_RESP_OKAY;
          end
        end
        else if (awa_q == `EBCT_STATUS_OFS)
          BRESP <= `EBCT_RESP_OKAY;
      end
    end
  end

  // read channel, status shows sequencer state and active channel
  always @(posedge CLK)
  begin
    if (RST)
    begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= `EBCT_RESP_OKAY;
    end
    else if (RVALID)
    begin
      if (RREADY)
        RVALID <= 1'b0;
    end
    else if (ARVALID)
    begin
      RVALID <= 1'b1;
      RRESP  <= `EBCT_RESP_OKAY;
      RDATA  <= 32'h0000_0000;
      if (r_chok && r_lo)
        RDATA <= lo_q[rch];
      else if (r_chok && r_hi)
        RDATA <= hi_q[rch];
      else if (ARADDR == `EBCT_STATUS_OFS)
        RDATA <= {24'h00_0000, 1'b0, ch_q, 1'b0, st_q};
      else
        RRESP <= `EBCT_RESP_SLVERR;
    end
  end

  // acknowledge/ready synchroniser
  always @(posedge CLK)
  begin
    if (RST)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      sync1_q <= ACK_READY_IN;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // access sequencer; every step except idle and acknowledge advances on a channel clock tick
  always @(posedge CLK)
  begin
    if (RST)
    begin
      st_q          <= S_IDLE;
      ch_q          <= 3'h0;
      wr_q          <= 1'b0;
      beats_q       <= 2'h0;
      bytes_q       <= 4'h0;
      cnt_q         <= 6'h00;
      div_q         <= 2'h0;
      first_q       <= 1'b0;
      CE_N          <= 1'b1;
      STROBE_N      <= 1'b1;
      BYTE_STROBE_N <= 4'hF;
      BEAT_ADDR     <= 2'h0;
      DONE          <= 1'b0;
      ERR           <= 1'b0;
    end
    else
    begin
      DONE  <= 1'b0;
      ERR   <= 1'b0;
      div_q <= tick ? div_max : div_q - 2'h1;                               // RULE11
      case (st_q)
        S_IDLE:
          if (REQ_VALID && !rst_seen_q)
          begin
            if (!ch_on)
              ERR <= 1'b1;                                                  // RULE12
            else
            begin
              ch_q      <= REQ_CH;
              wr_q      <= REQ_WRITE;
              beats_q   <= REQ_BEATS;
              bytes_q   <= REQ_BYTES;
              BEAT_ADDR <= 2'h0;                                            // RULE16
              first_q   <= 1'b1;
              cnt_q     <= {3'h0, lo_q[REQ_CH][`EBCT_F_SETUP_HOLD_WAIT_HI:`EBCT_F_SETUP_HOLD_WAIT_LO]};
              div_q     <= 2'h0;
              st_q      <= S_AS;
            end
          end
        S_AS:
          if (tick)
          begin
            if (cnt_q == 6'h00)
            begin
              CE_N  <= 1'b0;                                                // RULE14
              cnt_q <= {3'h0, setup_hold_wait};                                        // RULE13
              st_q  <= S_CS;
            end
            else
              cnt_q <= cnt_q - 6'h01;
          end
        S_CS:
          if (tick)
          begin
            if (cnt_q == 6'h00)
            begin
              STROBE_N      <= 1'b0;                                        // RULE14
              BYTE_STROBE_N <= (wr_q || !cfg[`EBCT_F_BC]) ? ~bytes_q : 4'hF; // RULE8
              cnt_q         <= rdy_mode ? wait_rdy : (page ? {2'h0, wt} : wait6); // RULE3
              st_q          <= ack_mode ? S_ACK : S_WAIT;
            end
            else
              cnt_q <= cnt_q - 6'h01;
          end
        S_WAIT:
          if (tick)
          begin
            if (cnt_q != 6'h00)
              cnt_q <= cnt_q - 6'h01;
            else if (rdy_mode && first_q)
              st_q <= S_ACK;                                                // RULE17
            else if (beats_q != 2'h0)
            begin
              beats_q   <= beats_q - 2'h1;
              BEAT_ADDR <= BEAT_ADDR + 2'h1;                                // RULE16
              first_q   <= 1'b0;
              cnt_q     <= page ? {4'h0, page_wait_time} : (rdy_mode ? wait_rdy : wait6); // RULE1
            end
            else
            begin
              STROBE_N      <= 1'b1;
              BYTE_STROBE_N <= 4'hF;
              cnt_q         <= {3'h0, setup_hold_wait};
              st_q          <= S_CH;
            end
          end
        S_ACK:
          if (ack_ev)
          begin
            first_q <= 1'b0;
            if (beats_q != 2'h0)
            begin
              beats_q   <= beats_q - 2'h1;
              BEAT_ADDR <= BEAT_ADDR + 2'h1;
            end
            else
            begin
              STROBE_N      <= 1'b1;
              BYTE_STROBE_N <= 4'hF;
              cnt_q         <= {3'h0, setup_hold_wait};
              st_q          <= S_CH;
            end
          end
        S_CH:
          if (tick)
          begin
            if (cnt_q == 6'h00)
            begin
              CE_N  <= 1'b1;                                                // RULE14
              cnt_q <= {3'h0, setup_hold_wait};
              st_q  <= S_AH;
            end
            else
              cnt_q <= cnt_q - 6'h01;
          end
        S_AH:
          if (tick)
          begin
            if (cnt_q == 6'h00)
            begin
              DONE <= 1'b1;
              st_q <= S_IDLE;
            end
            else
              cnt_q <= cnt_q - 6'h01;
          end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// *** verif/ebct_monitor.sv ***
// Purpose: port checker for the channel timing block
// Assumes: synchronous active-high RST, one clock
// Notes: bound to the design top below the module
`timescale 1ns/1ps
module ebct_monitor (
  input wire        CLK,
  input wire        RST,
  input wire        ARVALID,
  input wire        ARREADY,
  input wire        RVALID,
  input wire        REQ_VALID,
  input wire        REQ_READY,
  input wire        CE_N,
  input wire        STROBE_N,
  input wire [3:0]  BYTE_STROBE_N,
  input wire [1:0]  BEAT_ADDR,
  input wire        DONE,
  input wire        ERR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // setup and hold ordering of select and strobe
  AST_STROBE_IN_CE: assert property (!STROBE_N |-> !CE_N) else $error("strobe outside select");
  AST_CE_SETUP: assert property ($fell(STROBE_N) |-> !$past(CE_N)) else $error("no select setup");
  AST_CE_HOLD: assert property ($rose(CE_N) |-> $past(STROBE_N)) else $error("no select hold");
  AST_LANES_IN_CE: assert property (BYTE_STROBE_N != 4'hf |-> !CE_N) else $error("lane outside select");
  // refusal and completion
  AST_ERR_NO_CYCLE: assert property (ERR |-> CE_N && !DONE) else $error("refused request cycled");
  AST_DONE_PULSE: assert property (DONE |=> !DONE && CE_N) else $error("done too long");
  AST_ONE_ACCESS: assert property (REQ_VALID && REQ_READY |=> ERR ^ !REQ_READY) else $error("second request taken");
  // burst beat numbering and read answer timing
  AST_BEAT_ZERO: assert property ($fell(CE_N) |-> BEAT_ADDR == 2'h0) else $error("beat not from zero");
  AST_BEAT_STEP: assert property (!CE_N && !$past(CE_N) && BEAT_ADDR != $past(BEAT_ADDR)
    |-> BEAT_ADDR == $past(BEAT_ADDR) + 2'h1) else $error("beat step not one");
  AST_READ_NEXT: assert property (ARVALID && ARREADY |=> RVALID) else $error("read answer late");
endmodule
bind ebct_channel_timing ebct_monitor u_mon (.*);

// *** verif/ebct_ext_dev.sv ***
// Purpose: external device answering with acknowledge or ready
// Assumes: answer delay set by the bench
// Notes: one-cycle pulses, low when idle
`timescale 1ns/1ps
module ebct_ext_dev (
  input wire       CLK,
  input wire       STROBE_N,
  input wire [3:0] DLY,
  output reg       ACK = 1'b0
);
  reg [3:0] cnt_q = 4'h0;
  // pulse after DLY strobe cycles, spaced so each pulse is a fresh edge
  always @(posedge CLK)
  begin
    ACK <= !STROBE_N && cnt_q == DLY;
    cnt_q <= (STROBE_N || cnt_q == DLY + 4'h3) ? 4'h0 : cnt_q + 4'h1;
  end
endmodule

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the channel timing block
// Assumes: expected notes queued by drivers, checked by a watcher
// Notes: channel 1 carries the access scenarios
`timescale 1ns/1ps
module testbench;
  reg         CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, REQ_VALID, REQ_WRITE;
  reg  [11:0] AWADDR, ARADDR;
  reg  [31:0] WDATA, r;
  reg  [3:0]  WSTRB, REQ_BYTES, dly, bs_acc;
  reg  [1:0]  STRAP_DATA_54, REQ_BEATS, bt_max;
  reg  [2:0]  STRAP_ADDR_876, REQ_CH;
  wire        AWREADY, WREADY, BVALID, ARREADY, RVALID, REQ_READY, ACK_READY_IN, CE_N, STROBE_N, DONE, ERR;
  wire [1:0]  BRESP, RRESP, BEAT_ADDR;
  wire [31:0] RDATA;
  wire [3:0]  BYTE_STROBE_N;
  integer     num_errors = 0, n_compared = 0, cyc = 0, t0 = 0, i;
  reg  [33:0] rd_q[$];
  reg  [1:0]  b_q[$];
  reg  [6:0]  a_q[$];
  integer     lo_q[$], hi_q[$];

  ebct_channel_timing DUT (.*);
  ebct_ext_dev u_dev (.CLK(CLK), .STROBE_N(STROBE_N), .DLY(dly), .ACK(ACK_READY_IN));

  // clock and cycle count
  initial
  begin
    CLK = 0;
    forever #2.5 CLK = ~CLK;
  end
  always @(posedge CLK) cyc <= cyc + 1;

  task chk_rd(input [33:0] e, input [33:0] g);
  begin
    n_compared++;
    if (e !== g) begin num_errors++; $display("unexpected rdata exp %h got %h", e, g); end
  end
  endtask
  task chk_wr(input [1:0] e, input [1:0] g);
  begin
    n_compared++;
    if (e !== g) begin num_errors++; $display("unexpected bresp exp %h got %h", e, g); end
  end
  endtask
  task chk_acc(input [6:0] e, input [6:0] g, input integer lat, lo, hi);
  begin
    n_compared += 2;
    if (e !== g) begin num_errors++; $display("unexpected access exp %h got %h", e, g); end
    if (lat < lo || lat > hi) begin num_errors++; $display("unexpected latency exp %0d..%0d got %0d", lo, hi, lat); end
  end
  endtask

  // watcher: each result takes the oldest note
  always @(posedge CLK)
  begin
    if (RVALID && RREADY) chk_rd(rd_q.pop_front(), {RRESP, RDATA});
    if (BVALID && BREADY) chk_wr(b_q.pop_front(), BRESP);
    if (REQ_VALID && REQ_READY) begin t0 = cyc; bs_acc = 4'hf; bt_max = 2'h0; end
    if (!CE_N) begin bs_acc = bs_acc & BYTE_STROBE_N; if (BEAT_ADDR > bt_max) bt_max = BEAT_ADDR; end
    if (DONE || ERR) chk_acc(a_q.pop_front(), {ERR, bt_max, bs_acc}, cyc - t0, lo_q.pop_front(), hi_q.pop_front());
  end

  task axw(input [11:0] a, input [31:0] d, input [1:0] e);
    reg got;
  begin
    b_q.push_back(e);
    got = 0;
    AWADDR <= a; WDATA <= d; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
    while (!got)
    begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 0;
      if (WREADY) WVALID <= 0;
      if (BVALID) begin got = 1; BREADY <= 0; end
    end
    @(posedge CLK);
  end
  endtask
  task axr(input [11:0] a, input [33:0] e);
    reg got;
  begin
    rd_q.push_back(e);
    got = 0;
    ARADDR <= a; ARVALID <= 1; RREADY <= 1;
    while (!got)
    begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 0;
      if (RVALID) begin got = 1; RREADY <= 0; end
    end
    @(posedge CLK);
  end
  endtask
  task acc(input [2:0] ch, input wr, input [1:0] bt, input [3:0] by, input [6:0] e, input integer lo, hi);
    reg got;
  begin
    a_q.push_back(e); lo_q.push_back(lo); hi_q.push_back(hi);
    got = 0;
    REQ_CH <= ch; REQ_WRITE <= wr; REQ_BEATS <= bt; REQ_BYTES <= by; REQ_VALID <= 1;
    while (!got)
    begin
      @(posedge CLK);
      if (REQ_READY) begin got = 1; REQ_VALID <= 0; end
    end
    while (!(DONE || ERR)) @(posedge CLK);
  end
  endtask

  // configure channel 1 and run one access with its expected span in clock cycles
  task run(input [1:0] pm, page_wait_time, input [3:0] wt, input bc, rdy, input [1:0] sp, input [2:0] sh,
           input wr, input [1:0] bt, input [3:0] by);
    integer p, w, l, ext;
  begin
    axw(12'h008, {12'h000, pm, page_wait_time, wt, 4'h0, bc, rdy, sp, 1'b1, sh}, 2'h0);
    p = 4 - sp;
    w = (pm != 0) ? wt : {page_wait_time, wt};
    ext = (rdy || w == 63) ? 300 : 0;
    if (rdy) w = w - w % 2;
    if (w == 63) w = 0;
    l = p * (5 + w + 4 * sh + bt * (1 + ((pm != 0) ? page_wait_time : w)));
    acc(3'h1, wr, bt, by, {1'b0, bt, (wr || !bc) ? ~by : 4'hf}, l - p, l + p * (bt * (3 + 4 * sh) + 1) + 1 + ext);
  end
  endtask

  task conclude;
  begin
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  // watchdog
  initial
  begin
    #400000;
    num_errors++;
    conclude;
  end

  // main sequence
  initial
  begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, REQ_VALID, REQ_WRITE} = 0;
    AWADDR = 0; ARADDR = 0; WDATA = 0; WSTRB = 4'hf; REQ_CH = 0; REQ_BEATS = 0; REQ_BYTES = 0; dly = 0;
    r = $urandom(32'h0000_ec32);
    STRAP_DATA_54 = $urandom;
    STRAP_ADDR_876 = $urandom;
    RST = 1;
    repeat (3) @(posedge CLK);
    RST <= 0;
    repeat (2) @(posedge CLK);
    axr(12'h000, {2'h0, 14'h0000, 2'h3, 3'h7, ~STRAP_DATA_54[0], 4'h2, STRAP_DATA_54[1], 1'b0,
                  STRAP_ADDR_876[1:0], STRAP_ADDR_876[2], 3'h0});
    axr(12'h008, 34'h0);
    acc(3'h1, 1'b0, 2'h0, 4'hf, 7'h4f, 0, 3);
    // register map, high and low words of every channel
    for (i = 0; i < 16; i = i + 1)
    begin
      r = $urandom;
      axw({i[9:0], 2'h0}, r, 2'h0);
      axr({i[9:0], 2'h0}, {2'h0, r & (i[0] ? 32'hFFFF_0000 : 32'h000F_FFFF)});
    end
    axw(12'h800, r, 2'h2);
    axr(12'h800, 34'h2_0000_0000);
    run(2'h0, 2'h0, 4'h0, 1'b0, 1'b0, 2'h3, 3'h0, 1'b0, 2'h0, 4'hf);
    // normal mode mix over speeds, lanes, directions, waits and setup
    for (i = 0; i < 12; i = i + 1)
    begin
      r = $urandom;
      if (r[5:0] == 6'h3f) r[0] = 1'b0;
      run(2'h0, r[5:4], r[3:0], i[2], 1'b0, i[1:0], r[8:6], i[3], r[10:9], r[14:11] | 4'h1);
    end
    run(2'h1, 2'h1, 4'h4, 1'b0, 1'b0, 2'h3, 3'h1, 1'b0, 2'h3, 4'h5);
    for (i = 0; i < 2; i = i + 1)
    begin
      dly = i * 6;
      run(2'h0, 2'h3, 4'hf, 1'b1, 1'b0, 2'h2, 3'h0, i[0], 2'h1, 4'hf);
      run(2'h0, 2'h0, 4'h5, 1'b0, 1'b1, 2'h3, 3'h1, 1'b1, 2'h0, 4'hf);
    end
    // status: idle state, last channel 1
    axr(12'h100, 34'h0_0000_0010);
    conclude;
  end
endmodule
